// ==== design/bscc_defs.svh ====
// Constants for the bit-test-skip, call and clear execution slice.
// Assumes the including file already knows nothing else; it holds macros only.
// Notes on behaviour
// RQ1: Register clear writes an all-zero byte to the addressed data register.
// RQ2: Register clear sets the zero flag and touches no other status flag.
// RQ3: Register clear is recognised by pattern 00 0001 1 plus a 7-bit address.
// RQ4: Register clear has one operand 0..127, one word, one instruction cycle.
// RQ5: Call pushes the next address, then loads its 11-bit target into pc bits 10..0.
// RQ6: Skip if set turns the next instruction into a no-op when the bit is 1.
// RQ7: Call takes two cycles; pc bits 12..11 come from high latch bits 4..3.
`ifndef BSCC_DEFS_SVH
`define BSCC_DEFS_SVH
`define BSCC_CLEAR_TOP 7'h03
`define BSCC_CLEAR_TOP_MSB 13
`define BSCC_CLEAR_TOP_LSB 7
`define BSCC_BTSS_TOP 4'h7
`define BSCC_BTSS_TOP_LSB 10
`define BSCC_CALL_TOP 3'h4
`define BSCC_CALL_TOP_LSB 11
`define BSCC_FADDR_MSB 6
`define BSCC_BSEL_MSB 9
`define BSCC_BSEL_LSB 7
`define BSCC_TARGET_MSB 10
`define BSCC_LATCH_HI 4
`define BSCC_LATCH_LO 3
`define BSCC_CLEAR_VALUE 8'h00
`define BSCC_RESET_PC 13'h0000
`define BSCC_NOP_WORD 14'h0000
`define BSCC_PHASES_PER_CYCLE 4
`endif

// ==== design/bscc_pkg.sv ====
// Types shared by the execution slice and its decoder.
// Assumes bscc_defs.svh is on the include path.
package bscc_pkg;
	typedef enum logic [1:0]
	{
		BSCC_Q1 = 2'b00,
		BSCC_Q2 = 2'b01,
		BSCC_Q3 = 2'b10,
		BSCC_Q4 = 2'b11
	} bscc_phase_e;

	typedef enum logic [1:0]
	{
		BSCC_OP_OTHER = 2'b00,
		BSCC_OP_CLEAR = 2'b01,
		BSCC_OP_BTSS = 2'b10,
		BSCC_OP_CALL = 2'b11
	} bscc_op_e;
endpackage : bscc_pkg

// ==== design/bscc_dec_if.sv ====
// Carrier between the execution slice and its decoder.
// Assumes bscc_pkg is compiled first.
interface bscc_dec_if;
	import bscc_pkg::*;
	logic [13:0] instr;
	bscc_op_e op;
	logic [6:0] faddr;
	logic [2:0] bsel;
	logic [10:0] target;
	modport dec (input instr, output op, output faddr, output bsel, output target);
	modport exe (output instr, input op, input faddr, input bsel, input target);
endinterface : bscc_dec_if

// ==== design/bscc_decode.sv ====
// Combinational decoder for the three executed opcodes.
// Assumes the instruction word is held stable by the execution slice.
`include "bscc_defs.svh"
module bscc_decode
	import bscc_pkg::*;
(
	// Decoder side of the carrier.
	bscc_dec_if.dec dif
);
	always_comb
	begin
		dif.faddr = dif.instr[`BSCC_FADDR_MSB:0];
		dif.bsel = dif.instr[`BSCC_BSEL_MSB:`BSCC_BSEL_LSB];
		dif.target = dif.instr[`BSCC_TARGET_MSB:0];
		if (dif.instr[`BSCC_CLEAR_TOP_MSB:`BSCC_CLEAR_TOP_LSB] == `BSCC_CLEAR_TOP) // [RQ3]
		begin
			dif.op = BSCC_OP_CLEAR;
		end
		else if (dif.instr[13:`BSCC_BTSS_TOP_LSB] == `BSCC_BTSS_TOP)
		begin
			dif.op = BSCC_OP_BTSS;
		end
		else if (dif.instr[13:`BSCC_CALL_TOP_LSB] == `BSCC_CALL_TOP)
		begin
			dif.op = BSCC_OP_CALL;
		end
		else
		begin
			dif.op = BSCC_OP_OTHER;
		end
	end
endmodule : bscc_decode

// ==== design/bscc_exec.sv ====
// Execution slice for bit test skip if set, subroutine call and register clear.
// Assumes the program word at o_pc is on i_instr during phase Q1, and that the data
// register at o_f_addr is on i_f_data during phase Q3; both are synchronous to i_clk.
`include "bscc_defs.svh"
module bscc_exec
	import bscc_pkg::*;
#(
	parameter int PC_W = 13
)
(
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Program side.
	input wire logic [13:0] i_instr,
	input wire logic [7:0] i_pc_hi_latch,
	output logic [PC_W-1:0] o_pc,
	output logic [1:0] o_phase,
	output logic o_nop_cycle,
	// Data register side.
	input wire logic [7:0] i_f_data,
	output logic [6:0] o_f_addr,
	output logic o_f_wr,
	output logic [7:0] o_f_wdata,
	output logic o_z_set,
	// Hardware stack side.
	output logic o_push,
	output logic [PC_W-1:0] o_push_addr
);
	typedef struct packed
	{
		bscc_phase_e q;
		logic [13:0] ir;
		logic [PC_W-1:0] pc;
		logic [6:0] f_addr;
		logic f_wr;
		logic [7:0] f_wdata;
		logic z_set;
		logic push;
		logic [PC_W-1:0] push_addr;
		logic skip;
		logic call;
		logic nop_cyc;
		logic nop_next;
		logic hold_next;
	} bscc_state_s;

	bscc_state_s st_r;
	bscc_state_s st_nxt;
	bscc_dec_if dif ();

	bscc_decode u_decode
	(
		.dif(dif)
	);

	assign dif.instr = st_r.ir;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.f_wr = 1'b0;
		st_nxt.z_set = 1'b0;
		st_nxt.push = 1'b0;
		case (st_r.q)
			BSCC_Q1:
			begin
				// A flushed cycle runs an all-zero word, which decodes as none of ours.
				st_nxt.q = BSCC_Q2;
				st_nxt.nop_cyc = st_r.nop_next;
				st_nxt.ir = st_r.nop_next ? `BSCC_NOP_WORD : i_instr; // [RQ6] [RQ7]
				st_nxt.nop_next = 1'b0;
				st_nxt.skip = 1'b0;
				st_nxt.call = 1'b0;
			end
			BSCC_Q2:
			begin
				st_nxt.q = BSCC_Q3;
				st_nxt.f_addr = dif.faddr; // [RQ4]
			end
			BSCC_Q3:
			begin
				st_nxt.q = BSCC_Q4;
				case (dif.op)
					BSCC_OP_CLEAR:
					begin
						st_nxt.f_wr = 1'b1; // [RQ1]
						st_nxt.f_wdata = `BSCC_CLEAR_VALUE; // [RQ1]
						st_nxt.z_set = 1'b1; // [RQ2]
					end
					BSCC_OP_BTSS:
					begin
						// The bit is taken at the edge that ends Q3, while the data register is presented.
						st_nxt.skip = i_f_data[dif.bsel]; // [RQ6]
					end
					BSCC_OP_CALL:
					begin
						st_nxt.call = 1'b1;
						st_nxt.push = 1'b1; // [RQ5]
						st_nxt.push_addr = PC_W'(st_r.pc + 1'b1); // [RQ5]
					end
					default:
					begin
						st_nxt.skip = 1'b0;
					end
				endcase
			end
			default:
			begin
				st_nxt.q = BSCC_Q1;
				if (st_r.call)
				begin
					// The call target is in place now, so its flushed cycle must not advance it.
					st_nxt.pc = {i_pc_hi_latch[`BSCC_LATCH_HI:`BSCC_LATCH_LO], dif.target}; // [RQ5] [RQ7]
					st_nxt.nop_next = 1'b1; // [RQ7]
					st_nxt.hold_next = 1'b1; // [RQ7]
				end
				else if (st_r.hold_next)
				begin
					st_nxt.hold_next = 1'b0;
				end
				else
				begin
					st_nxt.pc = PC_W'(st_r.pc + 1'b1);
					st_nxt.nop_next = st_r.skip; // [RQ6]
				end
			end
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			st_r <= '0;
			st_r.q <= BSCC_Q1;
			st_r.pc <= `BSCC_RESET_PC;
			st_r.ir <= `BSCC_NOP_WORD;
			st_r.f_wdata <= `BSCC_CLEAR_VALUE;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign o_pc = st_r.pc;
	assign o_phase = st_r.q;
	assign o_nop_cycle = st_r.nop_cyc;
	assign o_f_addr = st_r.f_addr;
	assign o_f_wr = st_r.f_wr;
	assign o_f_wdata = st_r.f_wdata;
	assign o_z_set = st_r.z_set;
	assign o_push = st_r.push;
	assign o_push_addr = st_r.push_addr;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);
	// Properties see registered outputs, so each checks a decision one clock after the edge that makes it.

	property p_clear_zero;
		o_f_wr |-> o_f_wdata == `BSCC_CLEAR_VALUE && o_phase == BSCC_Q4;
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("clear wrote a nonzero byte"); // [RQ1]

	property p_clear_flag;
		o_z_set == o_f_wr && !(o_z_set && o_push);
	endproperty
	a_clear_flag: assert property (p_clear_flag) else $error("zero flag not paired with clear"); // [RQ2]

	property p_clear_decode;
		(o_phase == BSCC_Q3 && st_r.ir[13:7] == `BSCC_CLEAR_TOP)
			|=> o_f_wr && o_f_addr == $past(st_r.ir[6:0]);
	endproperty
	a_clear_decode: assert property (p_clear_decode) else $error("clear pattern not executed"); // [RQ3]

	property p_clear_one_cycle;
		o_f_wr |=> o_phase == BSCC_Q1 && o_pc == $past(o_pc) + 13'h0001 ##1 !o_nop_cycle;
	endproperty
	a_clear_one_cycle: assert property (p_clear_one_cycle) else $error("clear took more than one cycle"); // [RQ4]

	property p_call_target;
		o_push |-> o_push_addr == o_pc + 13'h0001 ##1 o_pc[10:0] == $past(st_r.ir[10:0]);
	endproperty
	a_call_target: assert property (p_call_target) else $error("call push or target wrong"); // [RQ5]

	property p_skip_nop;
		(o_phase == BSCC_Q4 && st_r.skip && !st_r.call) |=> ##1 o_nop_cycle [*4] ##1 !o_nop_cycle;
	endproperty
	a_skip_nop: assert property (p_skip_nop) else $error("taken skip did not flush one cycle"); // [RQ6]

	property p_call_high;
		o_push |=> o_pc[12:11] == $past(i_pc_hi_latch[4:3]) ##1 o_nop_cycle [*4] ##1 o_pc == $past(o_pc, 5);
	endproperty
	a_call_high: assert property (p_call_high) else $error("call high bits or flush wrong"); // [RQ7]

	property p_phase_walk;
		o_phase == BSCC_Q1 |=> o_phase == BSCC_Q2 ##1 o_phase == BSCC_Q3
			##1 o_phase == BSCC_Q4 ##1 o_phase == BSCC_Q1;
	endproperty
	a_phase_walk: assert property (p_phase_walk) else $error("instruction cycle is not four phases"); // [RQ4]

	property p_flush_quiet;
		o_nop_cycle |-> !o_f_wr && !o_push;
	endproperty
	a_flush_quiet: assert property (p_flush_quiet) else $error("flushed cycle had an effect"); // [RQ6]

	property p_call_quiet;
		o_push |-> o_phase == BSCC_Q4 && !o_nop_cycle;
	endproperty
	a_call_quiet: assert property (p_call_quiet) else $error("push outside Q4 of a live call"); // [RQ5]

	property p_skip_clear_bit;
		(o_phase == BSCC_Q3 && dif.op == BSCC_OP_BTSS && !i_f_data[dif.bsel]) |=> !st_r.skip ##2 !o_nop_cycle;
	endproperty
	a_skip_clear_bit: assert property (p_skip_clear_bit) else $error("skip taken on a clear bit"); // [RQ6]

	c_clear: cover property (o_f_wr);
	c_skip: cover property (o_phase == BSCC_Q4 && st_r.skip);
	c_call: cover property (o_push ##1 o_nop_cycle);
	c_other: cover property (o_phase == BSCC_Q4 && dif.op == BSCC_OP_OTHER && !o_nop_cycle);
	c_skip_not_taken: cover property (o_phase == BSCC_Q4 && dif.op == BSCC_OP_BTSS && !st_r.skip);
endmodule : bscc_exec

// ==== sim/bscc_tb.sv ====
// Self-checking bench for the bit test skip, call and clear execution slice.
// Assumes the design files are compiled first; the bench plays program, data and latch sources.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import bscc_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic [13:0] i_instr = 14'h0000;
	logic [7:0] i_pc_hi_latch = 8'h00;
	logic [7:0] i_f_data = 8'h00;
	logic [12:0] o_pc;
	logic [1:0] o_phase;
	logic o_nop_cycle;
	logic [6:0] o_f_addr;
	logic o_f_wr;
	logic [7:0] o_f_wdata;
	logic o_z_set;
	logic o_push;
	logic [12:0] o_push_addr;
	logic [12:0] pc0;
	int errors = 0;
	int check_count = 0;
	int cycles = 0;

	bscc_exec #(.PC_W(13)) dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_instr(i_instr), .i_pc_hi_latch(i_pc_hi_latch),
		.o_pc(o_pc), .o_phase(o_phase), .o_nop_cycle(o_nop_cycle), .i_f_data(i_f_data),
		.o_f_addr(o_f_addr), .o_f_wr(o_f_wr), .o_f_wdata(o_f_wdata), .o_z_set(o_z_set),
		.o_push(o_push), .o_push_addr(o_push_addr));

	initial
	begin
		forever #20 i_clk = ~i_clk;
	end

	task test_done();
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done

	// Phase waits are bounded, so any other hang is cut here well after all scenarios should have ended.
	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			errors++;
			test_done();
		end
	end

	task check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
			$display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
		if (seen !== exp)
			errors++;
	endtask : check

	task automatic to_phase(input logic [1:0] ph);
		int n;
		n = 0;
		@(negedge i_clk);
		while (o_phase !== ph && n < 8)
		begin
			@(negedge i_clk);
			n++;
		end
	endtask : to_phase

	// Presents a word in Q1 and returns in Q4 of the same instruction cycle.
	task issue(input logic [13:0] w, input logic [7:0] d);
		to_phase(2'h0);
		pc0 = o_pc;
		i_instr = w;
		i_f_data = d;
		to_phase(2'h3);
		i_instr = 14'h0000;
	endtask : issue

	// A clear word offered in a flushed cycle must not be executed.
	task flushed(input logic [12:0] pc_in, input logic [12:0] pc_out);
		to_phase(2'h0);
		check(o_pc, pc_in);
		i_instr = 14'h01aa;
		to_phase(2'h2);
		check(o_nop_cycle, 1'b1);
		to_phase(2'h3);
		check(o_f_wr, 1'b0);
		check(o_push, 1'b0);
		i_instr = 14'h0000;
		to_phase(2'h0);
		check(o_pc, pc_out);
	endtask : flushed

	task t_clear(input logic [6:0] a);
		issue({7'h03, a}, 8'h5a);
		check(o_phase, 2'h3);
		check(o_f_wr, 1'b1);
		check(o_f_wdata, 8'h00);
		check(o_f_addr, a);
		check(o_z_set, 1'b1);
		check(o_push, 1'b0);
		to_phase(2'h0);
		check(o_pc, {pc0 + 13'h0001});
		check(o_f_wr, 1'b0);
	endtask : t_clear

	task t_other(input logic [13:0] w);
		issue(w, 8'h5a);
		check(o_f_wr, 1'b0);
		check(o_z_set, 1'b0);
		to_phase(2'h0);
		check(o_pc, {pc0 + 13'h0001});
	endtask : t_other

	task t_skip(input logic [2:0] b);
		issue({4'h7, b, 7'h22}, 8'h01 << b);
		check(o_f_addr, 7'h22);
		check(o_f_wr, 1'b0);
		flushed({pc0 + 13'h0001}, {pc0 + 13'h0002});
		issue({4'h7, b, 7'h22}, ~(8'h01 << b));
		to_phase(2'h0);
		check(o_pc, {pc0 + 13'h0001});
		to_phase(2'h2);
		check(o_nop_cycle, 1'b0);
	endtask : t_skip

	task t_call(input logic [10:0] k, input logic [7:0] latch);
		i_pc_hi_latch = latch;
		issue({3'h4, k}, 8'h00);
		check(o_push, 1'b1);
		check(o_push_addr, {pc0 + 13'h0001});
		check(o_f_wr, 1'b0);
		flushed({latch[4:3], k}, {latch[4:3], k});
	endtask : t_call

	initial
	begin
		repeat (8) @(negedge i_clk);
		i_rst_b = 1'b1;
		t_clear(7'h00);
		t_clear(7'h7f);
		t_clear(7'h35);
		t_other(14'h0135);
		t_other(14'h00b5);
		for (int b = 0; b < 8; b++)
			t_skip(3'(b));
		t_call(11'h555, 8'hf7);
		t_call(11'h7ff, 8'h08);
		t_clear(7'h41);
		test_done();
	end
endmodule : tb
